// *** rtl/pxb_ctrl.sv ***
// Peripheral I/O bus controller top: host PIO request port, config port,
// strobes, selects and data direction. Assumes host holds request until done.
`timescale 1ns/10ps
module pxb_ctrl
	import pxb_pkg::*;
(
	input wire logic sys_clk,
	input wire logic nrst,
	input wire logic mem_addr_strap,
	input wire logic host_req,
	input wire logic host_write,
	input wire logic [PXB_ADDR_W-1:0] host_addr,
	input wire logic [PXB_DATA_W-1:0] host_wdata,
	output logic host_done,
	output logic host_err,
	output logic [PXB_DATA_W-1:0] host_rdata,
	input wire logic [3:0] cfg_addr,
	input wire logic [31:0] cfg_wdata,
	input wire logic cfg_wr,
	input wire logic cfg_rd,
	output logic [31:0] cfg_rdata,
	output logic [PXB_NCS-1:0] periph_cs_n,
	input wire logic [PXB_NCS-1:0] arb_req_in,
	output logic periph_rd_n,
	output logic periph_wr_n,
	output logic periph_data_dir_write_n,
	output logic [PXB_DATA_W-1:0] periph_wdata,
	output logic periph_wdata_oe,
	input wire logic [PXB_DATA_W-1:0] periph_rdata,
	output logic [PXB_NCS-1:0] arb_req_out,
	output logic arbiter_mode
);
	typedef enum logic [1:0] {PXB_IDLE, PXB_RUN, PXB_DONE} pxb_state_t;
	// Status word: last space, busy flag, arbiter mode
	typedef struct packed {
		logic [27:0] zero;
		logic arb_mode;
		logic busy;
		logic [1:0] space;
	} pxb_status_t;
	// All state in one word; the reset synchroniser sits apart on the raw reset
	typedef struct packed {
		logic strap_taken;
		logic arb_mode;
		pxb_state_t state;
		logic is_write;
		logic [1:0] space;
		logic [PXB_PRE_W-1:0] pre;
		logic [PXB_MASK_W-1:0] shift;
		logic [PXB_LEN_W-1:0] left;
		logic [31:0] cyc_reg;
		logic [31:0] mask_reg;
		logic [PXB_DATA_W-1:0] rdata;
		logic [PXB_DATA_W-1:0] wdata;
		logic done;
		logic err;
		logic [31:0] cfg_rdata;
		logic [PXB_NCS-1:0] cs_n;
		logic rd_n;
		logic wr_n;
		logic dir_n;
	} pxb_ctrl_t;
	pxb_ctrl_t st, next_st;
	logic [1:0] rst_sync;
	logic rst_n;
	logic tick;
	logic last_tick;
	logic take;
	logic refuse;
	logic pre_restart;
	logic in_win;
	logic [1:0] win;
	logic [PXB_NCS-1:0] win_hit;
	logic [PXB_LEN_W-1:0] space_len [PXB_NSPACE];
	logic [PXB_MASK_W-1:0] space_mask [PXB_NSPACE];
	logic [PXB_LEN_W-1:0] len_sel;
	logic [PXB_MASK_W-1:0] mask_sel;
	logic strobe_lvl;
	pxb_status_t status_word;
	assign rst_n = rst_sync[1];
	// Address bits 31:14 must match the base; 4KB per window
	assign in_win = host_addr[31:14] == PXB_WIN_BASE[31:14];
	assign win = host_addr[PXB_WIN_SHIFT+1:PXB_WIN_SHIFT];
	// Fields unpacked once per space so the loader is a plain index
	for (genvar k = 0; k < PXB_NSPACE; k++) begin : g_space
		assign space_len[k] = st.cyc_reg[PXB_CYC_LEN_POS + PXB_LEN_W*k +: PXB_LEN_W];
		assign space_mask[k] = st.mask_reg[PXB_MASK_W*k +: PXB_MASK_W];
	end
	// Last window drives no select; outside logic decodes it
	for (genvar k = 0; k < PXB_NCS; k++) begin : g_sel
		assign win_hit[k] = in_win && (win == 2'(k));
	end
	assign len_sel = space_len[win];
	assign mask_sel = space_mask[win];
	// Only the host port starts an access; no other master path exists
	assign take = host_req && st.strap_taken && (st.state == PXB_IDLE);
	assign refuse = !in_win || st.arb_mode;
	assign pre_restart = st.state == PXB_IDLE;
	// Lengths of 0 and 1 both end on the first tick
	assign last_tick = tick && (st.left <= PXB_LEN_W'(1));
	// Current mask bit; 0 asserts, 1 negates
	assign strobe_lvl = st.shift[0];
	assign status_word.zero = '0;
	assign status_word.arb_mode = st.arb_mode;
	assign status_word.busy = st.state == PXB_RUN;
	assign status_word.space = st.space;
	pxb_prescaler #(
		.W(PXB_PRE_W)
	) u_pre (
		.clk(sys_clk),
		.rst_n(rst_n),
		.restart(pre_restart),
		// Divider latched per access; a config write mid-cycle cannot stretch it
		.div_code(st.pre),
		.tick(tick)
	);
	always_comb begin
		next_st = st;
		next_st.done = 1'b0;
		next_st.err = 1'b0;
		next_st.cfg_rdata = 32'h0000_0000;
		// Strap caught once after reset release, never under reset
		if (!st.strap_taken) begin
			next_st.strap_taken = 1'b1;
			next_st.arb_mode = ~mem_addr_strap;
		end
		if (cfg_wr) begin
			unique case (cfg_addr)
				PXB_REG_CYCLE: begin
					next_st.cyc_reg = cfg_wdata;
				end
				PXB_REG_MASK: begin
					next_st.mask_reg = cfg_wdata;
				end
				default: ;
			endcase
		end
		if (cfg_rd) begin
			unique case (cfg_addr)
				PXB_REG_CYCLE: begin
					next_st.cfg_rdata = st.cyc_reg;
				end
				PXB_REG_MASK: begin
					next_st.cfg_rdata = st.mask_reg;
				end
				PXB_REG_STATUS: begin
					next_st.cfg_rdata = status_word;
				end
				default: next_st.cfg_rdata = 32'h0000_0000;
			endcase
		end
		unique case (st.state)
			PXB_IDLE: begin
				// Out-of-window and arbiter-mode requests end at once with an error
				if (take) begin
					if (refuse) begin
						next_st.err = 1'b1;
						next_st.state = PXB_DONE;
					end else begin
						next_st.state = PXB_RUN;
						next_st.is_write = host_write;
						next_st.space = win;
						next_st.wdata = host_wdata;
						// All the access needs is latched here; config writes cannot disturb it
						next_st.shift = mask_sel;
						next_st.left = len_sel;
						next_st.pre = st.cyc_reg[PXB_CYC_PRE_POS +: PXB_PRE_W];
						next_st.dir_n = ~host_write;
						// Fourth window leaves every select high
						next_st.cs_n = ~win_hit;
					end
				end
			end
			PXB_RUN: begin
				// Present mask bit drives the matching strobe only
				next_st.rd_n = st.is_write | strobe_lvl;
				next_st.wr_n = ~st.is_write | strobe_lvl;
				if (tick) begin
					// Fills with ones so a short mask leaves the strobe negated
					next_st.shift = {1'b1, st.shift[PXB_MASK_W-1:1]};
					if (last_tick) begin
						// Sampled while still selected; writes keep the last read word
						if (!st.is_write) begin
							next_st.rdata = periph_rdata;
						end
						next_st.done = 1'b1;
						next_st.state = PXB_DONE;
						next_st.cs_n = '1;
						next_st.rd_n = 1'b1;
						next_st.wr_n = 1'b1;
						next_st.dir_n = 1'b1;
					end else begin
						next_st.left = st.left - 1'b1;
					end
				end
			end
			PXB_DONE: begin
				// One idle cycle lets the host drop its request
				next_st.state = PXB_IDLE;
			end
			default: next_st.state = PXB_IDLE;
		endcase
		if (st.arb_mode) begin
			next_st.cs_n = '1;
			next_st.rd_n = 1'b1;
			next_st.wr_n = 1'b1;
			// Shared pins belong to the arbiter; never steer the transceiver
			next_st.dir_n = 1'b1;
		end
	end
	// Reset lifts in step with the clock; only the second stage is read
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			rst_sync <= 2'h0;
		end else begin
			rst_sync <= {rst_sync[0], 1'b1};
		end
	end
	// Internal reset copy loads every field; only constants here
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			st.strap_taken <= 1'b0;
			st.arb_mode <= 1'b0;
			st.state <= PXB_IDLE;
			st.is_write <= 1'b0;
			st.space <= 2'h0;
			st.pre <= '0;
			st.shift <= '1;
			st.left <= '0;
			st.cyc_reg <= PXB_CYC_RESET;
			st.mask_reg <= PXB_MASK_RESET;
			st.rdata <= '0;
			st.wdata <= '0;
			st.done <= 1'b0;
			st.err <= 1'b0;
			st.cfg_rdata <= 32'h0000_0000;
			st.cs_n <= '1;
			st.rd_n <= 1'b1;
			st.wr_n <= 1'b1;
			st.dir_n <= 1'b1;
		end else begin
			st.strap_taken <= next_st.strap_taken;
			st.arb_mode <= next_st.arb_mode;
			st.state <= next_st.state;
			st.is_write <= next_st.is_write;
			st.space <= next_st.space;
			st.pre <= next_st.pre;
			st.shift <= next_st.shift;
			st.left <= next_st.left;
			st.cyc_reg <= next_st.cyc_reg;
			st.mask_reg <= next_st.mask_reg;
			st.rdata <= next_st.rdata;
			st.wdata <= next_st.wdata;
			st.done <= next_st.done;
			st.err <= next_st.err;
			st.cfg_rdata <= next_st.cfg_rdata;
			st.cs_n <= next_st.cs_n;
			st.rd_n <= next_st.rd_n;
			st.wr_n <= next_st.wr_n;
			st.dir_n <= next_st.dir_n;
		end
	end
	// Pins come straight from flops; done is the OR of two of them
	assign host_done = st.done | st.err;
	assign host_err = st.err;
	assign host_rdata = st.rdata;
	assign cfg_rdata = st.cfg_rdata;
	assign periph_cs_n = st.cs_n;
	assign periph_rd_n = st.rd_n;
	assign periph_wr_n = st.wr_n;
	assign periph_data_dir_write_n = st.dir_n;
	assign periph_wdata = st.wdata;
	// Data pins driven only while the transceiver points outward
	assign periph_wdata_oe = ~st.dir_n;
	// Select pins become request inputs in arbiter mode
	assign arb_req_out = st.arb_mode ? arb_req_in : '0;
	assign arbiter_mode = st.arb_mode;
endmodule

// *** rtl/pxb_pkg.sv ***
// Package for the peripheral I/O bus controller: window map, field layout,
// reset values and timing figures. Assumes nothing of its surroundings.
package pxb_pkg;
	localparam logic [31:0] PXB_WIN_BASE = 32'h4001_0000;
	localparam int PXB_WIN_SHIFT = 12;
	localparam logic [1:0] PXB_WIN_NOCS = 2'h3;
	localparam int PXB_ADDR_W = 32;
	localparam int PXB_DATA_W = 32;
	localparam int PXB_NCS = 3;
	localparam int PXB_NSPACE = 4;
	localparam int PXB_MASK_W = 8;
	localparam int PXB_LEN_W = 4;
	localparam int PXB_PRE_W = 2;
	localparam logic [3:0] PXB_REG_CYCLE = 4'h0;
	localparam logic [3:0] PXB_REG_MASK = 4'h4;
	localparam logic [3:0] PXB_REG_STATUS = 4'h8;
	localparam int PXB_CYC_LEN_POS = 0;
	localparam int PXB_CYC_PRE_POS = 16;
	localparam logic [31:0] PXB_CYC_RESET = 32'h0000_7777;
	localparam logic [31:0] PXB_MASK_RESET = 32'hF1F1_F1F1;
	localparam real PXB_CLK_NS = 5.0;
endpackage

// *** rtl/pxb_prescaler.sv ***
// Prescaler producing a one-cycle tick every 1 to 4 clocks.
// Assumes a synchronous active-low reset copy and a held divide code.
`timescale 1ns/10ps
module pxb_prescaler
	import pxb_pkg::*;
#(
	parameter int W = PXB_PRE_W
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic restart,
	input wire logic [W-1:0] div_code,
	output logic tick
);
	typedef struct packed {
		logic [W-1:0] cnt;
	} pxb_pre_t;
	pxb_pre_t st, next_st;
	always_comb begin
		next_st = st;
		tick = 1'b0;
		if (restart) begin
			next_st.cnt = '0;
		end else if (st.cnt >= div_code) begin
			next_st.cnt = '0;
			tick = 1'b1;
		end else begin
			next_st.cnt = st.cnt + 1'b1;
		end
	end
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end
endmodule

// *** sim/pxb_ctrl_assertions.sv ***
// Port checker for pxb_ctrl: strobe, select, direction and done relations.
// Assumes it is bound onto pxb_ctrl and sees only its ports.
`timescale 1ns/10ps
module pxb_ctrl_assertions
	import pxb_pkg::*;
(
	input wire logic sys_clk,
	input wire logic nrst,
	input wire logic host_done,
	input wire logic host_err,
	input wire logic [PXB_NCS-1:0] periph_cs_n,
	input wire logic [PXB_NCS-1:0] arb_req_in,
	input wire logic [PXB_NCS-1:0] arb_req_out,
	input wire logic periph_rd_n,
	input wire logic periph_wr_n,
	input wire logic periph_data_dir_write_n,
	input wire logic periph_wdata_oe,
	input wire logic arbiter_mode
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!nrst);
	sequence s_done_pulse;
		host_done ##1 !host_done;
	endsequence
	AST_DONE_PULSE: assert property (host_done |-> s_done_pulse)
		else $error("done held too long");
	AST_ERR_DONE: assert property (host_err |-> host_done)
		else $error("error without done");
	AST_RD_DIR: assert property (!periph_rd_n |-> periph_data_dir_write_n)
		else $error("read strobe in write");
	AST_WR_DIR: assert property (!periph_wr_n |-> !periph_data_dir_write_n)
		else $error("write strobe in read");
	AST_OE_DIR: assert property (periph_wdata_oe == !periph_data_dir_write_n)
		else $error("enable and direction disagree");
	AST_CS_ONE: assert property ($countones(~periph_cs_n) <= 1)
		else $error("two selects low");
	AST_ARB_PASS: assert property (arb_req_out == (arbiter_mode ? arb_req_in : 3'h0))
		else $error("request pins wrong");
	AST_ARB_IDLE: assert property (arbiter_mode |-> &periph_cs_n && periph_rd_n && periph_wr_n)
		else $error("bus used in arbiter mode");
	AST_END_IDLE: assert property (host_done |-> periph_rd_n && periph_wr_n && &periph_cs_n)
		else $error("strobe or select left on");
endmodule
bind pxb_ctrl pxb_ctrl_assertions pxb_ctrl_assertions_inst (.sys_clk(sys_clk), .nrst(nrst),
	.host_done(host_done), .host_err(host_err), .periph_cs_n(periph_cs_n),
	.arb_req_in(arb_req_in), .arb_req_out(arb_req_out), .periph_rd_n(periph_rd_n),
	.periph_wr_n(periph_wr_n), .periph_data_dir_write_n(periph_data_dir_write_n),
	.periph_wdata_oe(periph_wdata_oe), .arbiter_mode(arbiter_mode));

// *** sim/pxb_periph_model.sv ***
// Peripheral model echoing address bits 23:0 under a 5A top byte.
// Assumes the host address reaches it through an always-on buffer.
`timescale 1ns/10ps
module pxb_periph_model
	import pxb_pkg::*;
(
	input wire logic sys_clk,
	input wire logic [PXB_ADDR_W-1:0] addr,
	input wire logic [PXB_NCS-1:0] cs_n,
	input wire logic rd_n,
	output logic [PXB_DATA_W-1:0] rdata
);
	logic held = 1'b0;
	logic [PXB_DATA_W-1:0] last = 32'h0;
	// Hold lasts only while selected; free bus flips so stale data shows
	always @(posedge sys_clk) begin
		held <= (!rd_n || held) && !(&cs_n);
		last <= rdata;
	end
	assign rdata = (!rd_n || held) ? {8'h5A, addr[23:0]} : ~last;
endmodule

// *** sim/pxb_ctrl_tb.sv ***
// Testbench for pxb_ctrl: table of accesses, then error, reset, arbiter cases.
// Assumes the peripheral model on the far side and the bound checker.
`timescale 1ns/10ps
module pxb_ctrl_tb
	import pxb_pkg::*;
;
	typedef struct {logic [1:0] s; logic w; logic [1:0] pre; logic [3:0] len;
		logic [7:0] mask; int b;} pxb_row_t;
	pxb_row_t rows [4] = '{'{0, 1, 0, 7, 8'hF1, 3}, '{1, 0, 1, 7, 8'hF1, 3},
		'{2, 0, 2, 5, 8'hFC, 2}, '{3, 1, 3, 4, 8'hF9, 2}};
	pxb_row_t r;
	logic sys_clk = 0, nrst = 0, mem_addr_strap = 1, host_req = 0, host_write = 0;
	logic cfg_wr = 0, cfg_rd = 0, host_done, host_err, periph_rd_n, periph_wr_n;
	logic dir_n, wd_oe, arbiter_mode, e;
	logic [3:0] cfg_addr = 4'h0;
	logic [31:0] host_addr = 32'h0, host_wdata = 32'h0, cfg_wdata = 32'h0;
	logic [31:0] host_rdata, cfg_rdata, periph_wdata, periph_rdata, a, wd, rv;
	logic [2:0] periph_cs_n, arb_req_out, arb_req_in = 3'h0;
	int i, sc, cc, fails = 0, comparisons = 0, cyc = 0;
	pxb_ctrl pxb_ctrl_inst (.sys_clk(sys_clk), .nrst(nrst), .mem_addr_strap(mem_addr_strap),
		.host_req(host_req), .host_write(host_write), .host_addr(host_addr),
		.host_wdata(host_wdata), .host_done(host_done), .host_err(host_err),
		.host_rdata(host_rdata), .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata), .cfg_wr(cfg_wr),
		.cfg_rd(cfg_rd), .cfg_rdata(cfg_rdata), .periph_cs_n(periph_cs_n),
		.arb_req_in(arb_req_in), .periph_rd_n(periph_rd_n), .periph_wr_n(periph_wr_n),
		.periph_data_dir_write_n(dir_n), .periph_wdata(periph_wdata), .periph_wdata_oe(wd_oe),
		.periph_rdata(periph_rdata), .arb_req_out(arb_req_out), .arbiter_mode(arbiter_mode));
	pxb_periph_model pxb_periph_model_inst (.sys_clk(sys_clk), .addr(host_addr),
		.cs_n(periph_cs_n), .rd_n(periph_rd_n), .rdata(periph_rdata));
	initial begin
		forever #2.5 sys_clk = ~sys_clk;
	end
	task chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			fails++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task stop_test;
		$display("comparisons=%0d fails=%0d", comparisons, fails);
		if (fails == 0 && comparisons > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	task cfg_acc(input logic w, input logic [3:0] ad, input logic [31:0] dt);
		@(posedge sys_clk);
		cfg_addr <= ad;
		cfg_wdata <= dt;
		cfg_wr <= w;
		cfg_rd <= !w;
		@(posedge sys_clk);
		cfg_wr <= 1'b0;
		cfg_rd <= 1'b0;
		#1 rv = cfg_rdata;
	endtask
	// Counts strobe and select clocks; write data seen while strobe is low
	task acc(input logic w, input logic [31:0] ad, input logic [31:0] dt);
		sc = 0;
		cc = 0;
		@(posedge sys_clk);
		host_req <= 1'b1;
		host_write <= w;
		host_addr <= ad;
		host_wdata <= dt;
		for (int n = 0; n < 300 && host_done !== 1'b1; n++) begin
			@(posedge sys_clk);
			#1;
			if ((w ? periph_wr_n : periph_rd_n) === 1'b0) sc++;
			if ((w ? periph_wr_n : 1'b1) === 1'b0) wd = periph_wdata;
			if (periph_cs_n !== 3'h7) cc++;
		end
		e = host_err;
		host_req <= 1'b0;
		repeat (2) @(posedge sys_clk);
	endtask
	always @(posedge sys_clk) begin
		cyc++;
		if (cyc == 6000) begin
			fails++;
			stop_test();
		end
	end
	initial begin
		repeat (20) @(posedge sys_clk);
		nrst <= 1'b1;
		repeat (6) @(posedge sys_clk);
		#1 chk({periph_rd_n, periph_wr_n, dir_n, periph_cs_n}, 6'h3F);
		cfg_acc(0, PXB_REG_CYCLE, 0);
		chk(rv, PXB_CYC_RESET);
		cfg_acc(0, PXB_REG_MASK, 0);
		chk(rv, PXB_MASK_RESET);
		for (i = 0; i < 4; i++) begin
			r = rows[i];
			a = PXB_WIN_BASE + (32'(r.s) << PXB_WIN_SHIFT) + 32'hC;
			cfg_acc(1, PXB_REG_CYCLE, (32'h7777 & ~(32'hF << (4 * r.s))) |
				(32'(r.len) << (4 * r.s)) | (32'(r.pre) << PXB_CYC_PRE_POS));
			cfg_acc(1, PXB_REG_MASK, (32'hF1F1F1F1 & ~(32'hFF << (8 * r.s))) |
				(32'(r.mask) << (8 * r.s)));
			acc(r.w, a, 32'hC3A5_0F00 + i);
			chk(sc, r.b * (r.pre + 1));
			chk(r.s == 3 ? cc == 0 : cc >= r.len * (r.pre + 1) && cc <= r.len * (r.pre + 1) + 1, 1);
			chk(r.w ? wd : host_rdata, r.w ? 32'hC3A5_0F00 + i : {8'h5A, a[23:0]});
			chk(e, 0);
		end
		cfg_acc(0, PXB_REG_STATUS, 0);
		chk(rv, 32'h0000_0003);
		acc(1, 32'h4001_4000, 32'h0);
		chk({e, sc[3:0], cc[3:0]}, 9'h100);
		cfg_acc(0, 4'hC, 0);
		chk(rv, 32'h0);
		nrst <= 1'b0;
		mem_addr_strap <= 1'b0;
		repeat (20) @(posedge sys_clk);
		nrst <= 1'b1;
		arb_req_in <= 3'h5;
		repeat (6) @(posedge sys_clk);
		#1 chk({arbiter_mode, arb_req_out}, 4'hD);
		acc(0, PXB_WIN_BASE, 32'h0);
		chk({e, sc[3:0]}, 5'h10);
		cfg_acc(0, PXB_REG_STATUS, 0);
		chk(rv, 32'h0000_0008);
		stop_test();
	end
endmodule
